/* cpru_device.sv */
// configuration-port device end: key unlock and sector page reads
// assumes the host end on the same clock; page store filled by user port
// Behaviour
// R1: key command unlocks only on exact 64-bit match
// R2: unlock holds until exit, reconfigure or reset
// R3: i2c host sends only two operand bytes
// R4: only one of the two security levels applies
// R5: read starts at opcode, pointer page first
// R6: host waits retrieval delay before first operand
// R7: serial host shifts dummy bytes to read
// R8: i2c needs restart; stop ends and resets
// R9: transfer may end after first page
// R10: first page repeats; count is pages plus one for two or more pages
// R12: i2c inserts 16 then 4 filler bytes
// R13: page count uses low 14 count bits
// R14: port field 0x0 for i2c, 0x1 serial
// R15: locked device ignores programming commands
`include "cpru_defines.svh"
module cpru_device (
    input wire logic core_clk,
    input wire logic resetn,
    cpru_link_if.dev link,
    input wire logic key_check_enable,
    input wire logic [63:0] stored_key,
    input wire logic [2:0] page_ptr,
    input wire logic mem_wr_en,
    input wire logic mem_wr_sector,
    input wire logic [2:0] mem_wr_page,
    input wire logic [3:0] mem_wr_byte,
    input wire logic [7:0] mem_wr_data,
    output logic unlocked,
    output logic security_set,
    output logic security_plus_set,
    output logic prog_strobe,
    output logic [7:0] prog_opcode
);
    localparam int MEM_DEPTH = 2 << (`CPRU_PAGE_AW + `CPRU_BYTE_AW);

    cpru_pkg::cpru_dev_state_t state_reg;
    logic [7:0] mem_reg [MEM_DEPTH];
    logic [7:0] op_reg, b1_reg, rx_byte_reg;
    logic [1:0] opcnt_reg;
    logic [3:0] keycnt_reg, byte_idx_reg;
    logic [63:0] key_sr_reg;
    logic [13:0] cnt_reg, page_idx_reg;
    logic [2:0] base_reg;
    logic [4:0] pad_reg;
    logic sector_reg, rx_valid_reg;
    logic take, permit, last_oper;
    logic [1:0] nops;
    logic [2:0] rd_page;

    function automatic logic [7:0] mem_index(input logic sector, input logic [2:0] page,
                                             input logic [3:0] byte_no);
        mem_index = {sector, page, byte_no};
    endfunction : mem_index

    assign link.rx_valid = rx_valid_reg;
    assign link.rx_byte = rx_byte_reg;
    assign take = link.tx_frame && link.tx_valid;
    assign nops = link.port_i2c ? `CPRU_OPS_I2C : `CPRU_OPS_SERIAL; // see R3
    assign last_oper = opcnt_reg == nops - 2'h1;
    assign permit = !key_check_enable || unlocked; // see R15
    // duplicate of the pointer page comes second, then the pages after it
    assign rd_page = (page_idx_reg == 14'h0000) ? base_reg :
        base_reg + 3'(page_idx_reg - 14'h0001); // see R10

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < MEM_DEPTH; i++)
                mem_reg[i] <= 8'h00;
        end
        else if (mem_wr_en)
            mem_reg[mem_index(mem_wr_sector, mem_wr_page, mem_wr_byte)] <= mem_wr_data;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= cpru_pkg::CPRU_D_IDLE;
            op_reg <= 8'h00;
            b1_reg <= 8'h00;
            opcnt_reg <= 2'h0;
            keycnt_reg <= 4'h0;
            key_sr_reg <= 64'h0;
            cnt_reg <= 14'h0000;
        end
        else if (!link.tx_frame)
            state_reg <= cpru_pkg::CPRU_D_IDLE; // early end is no error; see R8 see R9
        else
        begin
            case (state_reg)
                cpru_pkg::CPRU_D_IDLE:
                    if (take)
                    begin
                        op_reg <= link.tx_byte;
                        opcnt_reg <= 2'h0;
                        keycnt_reg <= 4'h0;
                        state_reg <= cpru_pkg::CPRU_D_OPER;
                    end
                cpru_pkg::CPRU_D_OPER:
                    if (take)
                    begin
                        opcnt_reg <= opcnt_reg + 2'h1;
                        if (opcnt_reg == 2'h1)
                            b1_reg <= link.tx_byte;
                        // upper count bits dropped; see R13
                        if (link.port_i2c && opcnt_reg == 2'h1)
                            cnt_reg <= {6'h00, link.tx_byte};
                        else if (opcnt_reg == 2'h2)
                            cnt_reg <= {b1_reg[5:0], link.tx_byte};
                        if (last_oper)
                        begin
                            if (op_reg == `CPRU_OP_KEY)
                                state_reg <= cpru_pkg::CPRU_D_KEY;
                            else if (op_reg == `CPRU_OP_UREAD || op_reg == `CPRU_OP_CREAD)
                                state_reg <= link.port_i2c ? cpru_pkg::CPRU_D_WRS :
                                    cpru_pkg::CPRU_D_READ;
                            else
                                state_reg <= cpru_pkg::CPRU_D_DONE;
                        end
                    end
                cpru_pkg::CPRU_D_KEY:
                    if (take)
                    begin
                        key_sr_reg <= {key_sr_reg[55:0], link.tx_byte};
                        keycnt_reg <= keycnt_reg + 4'h1;
                        if (keycnt_reg == `CPRU_KEY_BYTES - 4'h1)
                            state_reg <= cpru_pkg::CPRU_D_DONE;
                    end
                cpru_pkg::CPRU_D_WRS:
                    if (link.tx_restart)
                        state_reg <= cpru_pkg::CPRU_D_READ; // see R8
                cpru_pkg::CPRU_D_READ:
                    state_reg <= cpru_pkg::CPRU_D_READ;
                cpru_pkg::CPRU_D_DONE:
                    state_reg <= cpru_pkg::CPRU_D_DONE;
                default:
                    state_reg <= cpru_pkg::CPRU_D_IDLE;
            endcase
        end
    end

    // unlock and security levels
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            unlocked <= 1'b0;
            security_set <= 1'b0;
            security_plus_set <= 1'b0;
            prog_strobe <= 1'b0;
            prog_opcode <= 8'h00;
        end
        else
        begin
            prog_strobe <= 1'b0;
            // key compared with the shifted-in last byte included
            if (state_reg == cpru_pkg::CPRU_D_KEY && take && link.tx_frame &&
                keycnt_reg == `CPRU_KEY_BYTES - 4'h1 && key_check_enable &&
                {key_sr_reg[55:0], link.tx_byte} == stored_key)
                unlocked <= 1'b1; // see R1 see R15
            if (state_reg == cpru_pkg::CPRU_D_OPER && take && link.tx_frame && last_oper)
            begin
                if (op_reg == `CPRU_OP_EXIT || op_reg == `CPRU_OP_REFRESH)
                    unlocked <= 1'b0; // see R2
                else if (permit && (op_reg == `CPRU_OP_SEC || op_reg == `CPRU_OP_SECPLUS ||
                         op_reg == `CPRU_OP_BURST))
                begin
                    // a second protection level is refused; see R4
                    if (!(security_set || security_plus_set) || op_reg == `CPRU_OP_BURST)
                    begin
                        prog_strobe <= 1'b1;
                        prog_opcode <= op_reg;
                        security_set <= security_set || op_reg == `CPRU_OP_SEC;
                        security_plus_set <= security_plus_set || op_reg == `CPRU_OP_SECPLUS;
                    end
                end
            end
        end
    end

    // page stream; pointer latched at the opcode so retrieval starts at once
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            base_reg <= 3'h0;
            sector_reg <= 1'b0;
            page_idx_reg <= 14'h0000;
            byte_idx_reg <= 4'h0;
            pad_reg <= 5'h00;
            rx_valid_reg <= 1'b0;
            rx_byte_reg <= 8'h00;
        end
        else
        begin
            rx_valid_reg <= 1'b0;
            if (state_reg == cpru_pkg::CPRU_D_IDLE && take)
            begin
                base_reg <= page_ptr; // see R5
                sector_reg <= link.tx_byte == `CPRU_OP_UREAD;
                page_idx_reg <= 14'h0000;
                byte_idx_reg <= 4'h0;
                pad_reg <= 5'h00;
            end
            else if (state_reg == cpru_pkg::CPRU_D_READ && take)
            begin
                rx_valid_reg <= 1'b1;
                if (pad_reg != 5'h00)
                begin
                    rx_byte_reg <= `CPRU_FILL_BYTE; // see R12
                    pad_reg <= pad_reg - 5'h01;
                end
                else if (page_idx_reg >= cnt_reg)
                    rx_byte_reg <= `CPRU_FILL_BYTE;
                else
                begin
                    rx_byte_reg <= mem_reg[mem_index(sector_reg, rd_page, byte_idx_reg)];
                    byte_idx_reg <= byte_idx_reg + 4'h1;
                    if (byte_idx_reg == `CPRU_LAST_BYTE)
                    begin
                        page_idx_reg <= page_idx_reg + 14'h0001;
                        // i2c filler after first page and after its repeat; see R12
                        if (link.port_i2c && page_idx_reg == 14'h0000 && cnt_reg > 14'h0001)
                            pad_reg <= `CPRU_I2C_GAP_FIRST;
                        else if (link.port_i2c && page_idx_reg == 14'h0001 &&
                                 cnt_reg > 14'h0002)
                            pad_reg <= `CPRU_I2C_GAP_DUP;
                    end
                end
            end
        end
    end
endmodule : cpru_device

/* cpru_defines.svh */
// constants of the configuration-port read and unlock link
// assumes inclusion by bare name from both link ends
`ifndef CPRU_DEFINES_SVH
`define CPRU_DEFINES_SVH
`define CPRU_OP_KEY 8'hbc
`define CPRU_OP_UREAD 8'hca
`define CPRU_OP_CREAD 8'h73
`define CPRU_OP_EXIT 8'h26
`define CPRU_OP_REFRESH 8'h79
`define CPRU_OP_SEC 8'hce
`define CPRU_OP_SECPLUS 8'hcf
`define CPRU_OP_BURST 8'h7a
`define CPRU_OPS_SERIAL 2'h3
`define CPRU_OPS_I2C 2'h2
`define CPRU_KEY_BYTES 4'h8
`define CPRU_KEY_BITS 64
`define CPRU_PAGE_AW 3
`define CPRU_BYTE_AW 4
`define CPRU_LAST_BYTE 4'hf
`define CPRU_CNT_BITS 14
`define CPRU_I2C_GAP_FIRST 5'h10
`define CPRU_I2C_GAP_DUP 5'h4
`define CPRU_PORT_I2C 4'h0
`define CPRU_PORT_SERIAL 4'h1
`define CPRU_FILL_BYTE 8'hff
`define CPRU_CLK_NS 4
`define CPRU_RETR_LARGE_NS 240
`define CPRU_RETR_SMALL_NS 360
`define CPRU_RETR_LARGE_CYC ((`CPRU_RETR_LARGE_NS + `CPRU_CLK_NS - 1) / `CPRU_CLK_NS)
`define CPRU_RETR_SMALL_CYC ((`CPRU_RETR_SMALL_NS + `CPRU_CLK_NS - 1) / `CPRU_CLK_NS)
`endif

/* cpru_pkg.sv */
// types of the configuration-port read and unlock link
// assumes nothing of its surroundings
package cpru_pkg;
    typedef enum logic [5:0] {
        CPRU_D_IDLE = 6'h01,
        CPRU_D_OPER = 6'h02,
        CPRU_D_KEY = 6'h04,
        CPRU_D_WRS = 6'h08,
        CPRU_D_READ = 6'h10,
        CPRU_D_DONE = 6'h20
    } cpru_dev_state_t;
    typedef enum logic [4:0] {
        CPRU_H_IDLE = 5'h01,
        CPRU_H_OPER = 5'h02,
        CPRU_H_KEY = 5'h04,
        CPRU_H_RD = 5'h08,
        CPRU_H_END = 5'h10
    } cpru_host_state_t;
endpackage : cpru_pkg

/* cpru_link_if.sv */
// byte link between configuration host and device, one clock
// assumes both ends run on the same core_clk
interface cpru_link_if;
    logic tx_frame;
    logic tx_valid;
    logic [7:0] tx_byte;
    logic tx_restart;
    logic port_i2c;
    logic rx_valid;
    logic [7:0] rx_byte;
    modport dev (
        input tx_frame,
        input tx_valid,
        input tx_byte,
        input tx_restart,
        input port_i2c,
        output rx_valid,
        output rx_byte
    );
    modport host (
        output tx_frame,
        output tx_valid,
        output tx_byte,
        output tx_restart,
        output port_i2c,
        input rx_valid,
        input rx_byte
    );
endinterface : cpru_link_if

/* cpru_host.sv */
// configuration host end: sends one command per start pulse
// assumes the device end on the same clock answers reads next cycle
`include "cpru_defines.svh"
module cpru_host (
    input wire logic core_clk,
    input wire logic resetn,
    cpru_link_if.host link,
    input wire logic start,
    input wire logic [7:0] cmd_opcode,
    input wire logic use_i2c,
    input wire logic large_device,
    input wire logic [13:0] want_pages,
    input wire logic [15:0] read_bytes,
    input wire logic [63:0] key,
    output logic busy,
    output logic done,
    output logic rd_valid,
    output logic [7:0] rd_data
);
    cpru_pkg::cpru_host_state_t state_reg;
    logic tx_frame_reg, tx_valid_reg, tx_restart_reg, i2c_reg, is_read_reg, is_key_reg;
    logic [7:0] tx_byte_reg, op_reg, retr_reg;
    logic [1:0] k_reg;
    logic [3:0] kb_reg;
    logic [15:0] n_reg, nbytes_reg;
    logic [13:0] cnt_reg;
    logic [63:0] key_reg;
    logic [1:0] nops;
    logic [7:0] retr_cyc;
    logic [7:0] operand;

    assign link.tx_frame = tx_frame_reg;
    assign link.tx_valid = tx_valid_reg;
    assign link.tx_byte = tx_byte_reg;
    assign link.tx_restart = tx_restart_reg;
    assign link.port_i2c = i2c_reg;
    // i2c omits the upper count operand byte; see R3
    assign nops = i2c_reg ? `CPRU_OPS_I2C : `CPRU_OPS_SERIAL;
    assign retr_cyc = large_device ? 8'(`CPRU_RETR_LARGE_CYC) : 8'(`CPRU_RETR_SMALL_CYC);

    always_comb
    begin
        operand = {i2c_reg ? `CPRU_PORT_I2C : `CPRU_PORT_SERIAL, 4'h0}; // see R14
        if (k_reg == 2'h1)
            operand = i2c_reg ? cnt_reg[7:0] : {2'h0, cnt_reg[13:8]};
        else if (k_reg == 2'h2)
            operand = cnt_reg[7:0];
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= cpru_pkg::CPRU_H_IDLE;
            tx_frame_reg <= 1'b0;
            tx_valid_reg <= 1'b0;
            tx_restart_reg <= 1'b0;
            tx_byte_reg <= 8'h00;
            i2c_reg <= 1'b0;
            is_read_reg <= 1'b0;
            is_key_reg <= 1'b0;
            op_reg <= 8'h00;
            retr_reg <= 8'h00;
            k_reg <= 2'h0;
            kb_reg <= 4'h0;
            n_reg <= 16'h0000;
            nbytes_reg <= 16'h0000;
            cnt_reg <= 14'h0000;
            key_reg <= 64'h0;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            tx_restart_reg <= 1'b0;
            if (retr_reg != 8'hff)
                retr_reg <= retr_reg + 8'h01;
            case (state_reg)
                cpru_pkg::CPRU_H_IDLE:
                    if (start)
                    begin
                        op_reg <= cmd_opcode;
                        i2c_reg <= use_i2c;
                        is_read_reg <= (cmd_opcode == `CPRU_OP_UREAD) ||
                            (cmd_opcode == `CPRU_OP_CREAD);
                        is_key_reg <= cmd_opcode == `CPRU_OP_KEY;
                        // duplicated first page needs one extra; see R10
                        cnt_reg <= (want_pages > 14'h0001) ? want_pages + 14'h0001 : want_pages;
                        nbytes_reg <= read_bytes;
                        key_reg <= key;
                        tx_frame_reg <= 1'b1;
                        tx_valid_reg <= 1'b1;
                        tx_byte_reg <= cmd_opcode;
                        retr_reg <= 8'h01;
                        k_reg <= 2'h0;
                        kb_reg <= 4'h0;
                        n_reg <= 16'h0000;
                        busy <= 1'b1;
                        state_reg <= cpru_pkg::CPRU_H_OPER;
                    end
                cpru_pkg::CPRU_H_OPER:
                    if (k_reg == nops)
                    begin
                        tx_valid_reg <= 1'b0;
                        if (is_key_reg)
                            state_reg <= cpru_pkg::CPRU_H_KEY;
                        else if (is_read_reg)
                        begin
                            tx_restart_reg <= i2c_reg; // see R8
                            state_reg <= cpru_pkg::CPRU_H_RD;
                        end
                        else
                            state_reg <= cpru_pkg::CPRU_H_END;
                    end
                    else if (is_read_reg && k_reg == 2'h0 && retr_reg < retr_cyc)
                        tx_valid_reg <= 1'b0; // see R6
                    else
                    begin
                        tx_valid_reg <= 1'b1;
                        tx_byte_reg <= operand;
                        k_reg <= k_reg + 2'h1;
                    end
                cpru_pkg::CPRU_H_KEY:
                    if (kb_reg == `CPRU_KEY_BYTES)
                    begin
                        tx_valid_reg <= 1'b0;
                        state_reg <= cpru_pkg::CPRU_H_END;
                    end
                    else
                    begin
                        tx_valid_reg <= 1'b1;
                        tx_byte_reg <= key_reg[63:56];
                        key_reg <= {key_reg[55:0], 8'h00};
                        kb_reg <= kb_reg + 4'h1;
                    end
                cpru_pkg::CPRU_H_RD:
                    if (n_reg == nbytes_reg)
                    begin
                        tx_valid_reg <= 1'b0;
                        state_reg <= cpru_pkg::CPRU_H_END; // see R9
                    end
                    else
                    begin
                        tx_valid_reg <= 1'b1;
                        tx_byte_reg <= 8'h00; // see R7
                        n_reg <= n_reg + 16'h0001;
                    end
                cpru_pkg::CPRU_H_END:
                begin
                    tx_frame_reg <= 1'b0;
                    tx_valid_reg <= 1'b0;
                    busy <= 1'b0;
                    done <= 1'b1;
                    state_reg <= cpru_pkg::CPRU_H_IDLE;
                end
                default:
                    state_reg <= cpru_pkg::CPRU_H_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_valid <= 1'b0;
            rd_data <= 8'h00;
        end
        else
        begin
            rd_valid <= link.rx_valid;
            rd_data <= link.rx_valid ? link.rx_byte : rd_data;
        end
    end
endmodule : cpru_host

/* cpru_link_sva.sv */
// link checker for the configuration read and unlock link
// assumes one core_clk and the link signals wired in as plain inputs
`include "cpru_defines.svh"
module cpru_link_sva (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic tx_frame,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tx_restart,
    input wire logic port_i2c,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    logic taken;
    logic rd_op;
    logic pend_reg;
    logic [4:0] cnt_reg;
    logic [7:0] first_reg;
    logic [6:0] gap_reg;
    assign taken = tx_frame && tx_valid;
    assign rd_op = taken && cnt_reg == 5'h00
        && (tx_byte == `CPRU_OP_UREAD || tx_byte == `CPRU_OP_CREAD);
    // saturates so long reads never wrap back to the opcode slot
    always_ff @(posedge core_clk or negedge resetn)
        if (!resetn)
            cnt_reg <= 5'h00;
        else if (!tx_frame)
            cnt_reg <= 5'h00;
        else if (taken && cnt_reg != 5'h1f)
            cnt_reg <= cnt_reg + 5'h01;
    always_ff @(posedge core_clk or negedge resetn)
        if (!resetn)
            first_reg <= 8'h00;
        else if (taken && cnt_reg == 5'h00)
            first_reg <= tx_byte;
    always_ff @(posedge core_clk or negedge resetn)
        if (!resetn)
            pend_reg <= 1'b0;
        else
            pend_reg <= rd_op || (pend_reg && tx_frame && !tx_valid);
    always_ff @(posedge core_clk or negedge resetn)
        if (!resetn)
            gap_reg <= 7'h00;
        else if (rd_op)
            gap_reg <= 7'h01;
        else if (gap_reg != 7'h7f)
            gap_reg <= gap_reg + 7'h01;
    retrieval_gap_a: assert property (taken && pend_reg |-> gap_reg >= 7'h3c)
        else $error("operand before retrieval delay");
    port_field_a: assert property (taken && pend_reg |-> tx_byte[7:4] == (port_i2c ? 4'h0 : 4'h1))
        else $error("wrong port field");
    i2c_operands_a: assert property (tx_restart |-> cnt_reg == 5'h03)
        else $error("restart after wrong operand count");
    restart_i2c_a: assert property (tx_restart |-> port_i2c && tx_frame)
        else $error("restart outside i2c frame");
    rx_after_byte_a: assert property (rx_valid |-> $past(taken))
        else $error("read byte without request");
    rx_stop_a: assert property (!tx_frame |=> !rx_valid)
        else $error("read byte after frame end");
    rx_hold_a: assert property (!rx_valid |-> $stable(rx_byte))
        else $error("read byte changed without answer");
    key_length_a: assert property ($fell(tx_frame) && first_reg == `CPRU_OP_KEY |-> cnt_reg == 5'h0c)
        else $error("key frame length wrong");
    cover property (rx_valid && !port_i2c);
    cover property (tx_restart ##1 tx_valid [*2]);
    cover property ($fell(tx_frame) && first_reg == `CPRU_OP_KEY);
endmodule : cpru_link_sva

/* config_page_read_unlock_test.sv */
// self-checking bench: host and device ends joined over the link
// assumes 250 mhz core_clk and design files compiled first
`include "cpru_defines.svh"
module config_page_read_unlock_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic start = 1'b0;
    logic [7:0] cmd_opcode = 8'h00;
    logic use_i2c = 1'b0;
    logic large_device = 1'b1;
    logic [13:0] want_pages = 14'h0001;
    logic [15:0] read_bytes = 16'h0000;
    logic [63:0] key = 64'h0;
    logic [63:0] stored_key = 64'h0123456789abcdef;
    logic [2:0] page_ptr = 3'h0;
    logic mem_wr_en = 1'b0;
    logic key_en = 1'b1;
    logic [7:0] mem_wr_data = 8'h00;
    logic busy, done, rd_valid, unlocked, sec, secp, prog_strobe;
    logic [7:0] rd_data, prog_opcode;
    logic [7:0] got[$];
    logic [7:0] exp[$];
    int fails = 0;
    int total_checks = 0;
    int strobes = 0;
    cpru_link_if link ();
    cpru_host u_cpru_host (.core_clk(core_clk), .resetn(resetn), .link(link), .start(start),
        .cmd_opcode(cmd_opcode), .use_i2c(use_i2c), .large_device(large_device),
        .want_pages(want_pages), .read_bytes(read_bytes), .key(key), .busy(busy),
        .done(done), .rd_valid(rd_valid), .rd_data(rd_data));
    cpru_device u_cpru_device (.core_clk(core_clk), .resetn(resetn), .link(link),
        .key_check_enable(key_en), .stored_key(stored_key), .page_ptr(page_ptr),
        .mem_wr_en(mem_wr_en), .mem_wr_sector(mem_wr_data[7]), .mem_wr_page(mem_wr_data[6:4]),
        .mem_wr_byte(mem_wr_data[3:0]), .mem_wr_data(mem_wr_data), .unlocked(unlocked),
        .security_set(sec), .security_plus_set(secp), .prog_strobe(prog_strobe),
        .prog_opcode(prog_opcode));
    cpru_link_sva u_cpru_link_sva (.core_clk(core_clk), .resetn(resetn),
        .tx_frame(link.tx_frame), .tx_valid(link.tx_valid), .tx_byte(link.tx_byte),
        .tx_restart(link.tx_restart), .port_i2c(link.port_i2c), .rx_valid(link.rx_valid),
        .rx_byte(link.rx_byte));
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        if (rd_valid === 1'b1)
            got.push_back(rd_data);
        if (prog_strobe === 1'b1)
            strobes++;
    end
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected byte at %0t: got %h, expected %h", $time, g, e);
        end
    endtask : chk_byte
    task automatic chk_flag(input logic g, input logic e);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected flag at %0t: got %h, expected %h", $time, g, e);
        end
    endtask : chk_flag
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    task automatic run_cmd(input logic [7:0] op, input logic i2c, input int want,
        input int nbytes, input logic [63:0] k);
        int n;
        got.delete();
        @(posedge core_clk);
        cmd_opcode <= op;
        use_i2c <= i2c;
        want_pages <= 14'(want);
        read_bytes <= 16'(nbytes);
        key <= k;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        n = 0;
        // done is a one-cycle pulse, so look between edges
        while (done !== 1'b1 && n < 4000)
        begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 4000)
        begin
            fails++;
            $display("unexpected hang at %0t: got %h, expected %h", $time, n, 1);
            report_and_stop();
        end
        repeat (3) @(negedge core_clk);
    endtask : run_cmd
    task automatic read_test(input logic [7:0] op, input logic i2c, input logic [2:0] p0,
        input int want, input int nbytes);
        int cnt;
        logic [2:0] pg;
        exp.delete();
        cnt = want > 1 ? want + 1 : 1;
        for (int k = 0; k < cnt; k++)
        begin
            pg = p0 + 3'((k > 0) ? k - 1 : 0);
            for (int b = 0; b < 16; b++)
                exp.push_back({op == `CPRU_OP_UREAD, pg, 4'(b)});
            if (i2c && k == 0 && cnt > 1)
                repeat (16) exp.push_back(`CPRU_FILL_BYTE);
            if (i2c && k == 1 && cnt > 2)
                repeat (4) exp.push_back(`CPRU_FILL_BYTE);
        end
        while (exp.size() < nbytes)
            exp.push_back(`CPRU_FILL_BYTE);
        @(posedge core_clk);
        page_ptr <= p0;
        run_cmd(op, i2c, want, nbytes, 64'h0);
        chk_byte(8'(got.size()), 8'(nbytes));
        chk_flag(busy, 1'b0);
        for (int i = 0; i < nbytes; i++)
            chk_byte(got[i], exp[i]);
        $display("read test done: op %h i2c %0d pages %0d", op, i2c, want);
    endtask : read_test
    initial
    begin
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 256; i++)
        begin
            @(posedge core_clk);
            mem_wr_en <= 1'b1;
            mem_wr_data <= 8'(i);
        end
        @(posedge core_clk);
        mem_wr_en <= 1'b0;
        run_cmd(`CPRU_OP_BURST, 1'b0, 1, 0, 64'h0);
        chk_byte(8'(strobes), 8'h00);
        run_cmd(`CPRU_OP_KEY, 1'b0, 1, 0, stored_key ^ 64'h1);
        chk_flag(unlocked, 1'b0);
        for (int j = 0; j < 2; j++)
        begin
            run_cmd(`CPRU_OP_KEY, 1'b0, 1, 0, stored_key);
            chk_flag(unlocked, 1'b1);
            run_cmd(j ? `CPRU_OP_REFRESH : `CPRU_OP_EXIT, 1'b0, 1, 0, 64'h0);
            chk_flag(unlocked, 1'b0);
        end
        run_cmd(`CPRU_OP_KEY, 1'b0, 1, 0, stored_key);
        run_cmd(`CPRU_OP_BURST, 1'b0, 1, 0, 64'h0);
        chk_byte(8'(strobes), 8'h01);
        chk_byte(prog_opcode, `CPRU_OP_BURST);
        run_cmd(`CPRU_OP_SEC, 1'b0, 1, 0, 64'h0);
        run_cmd(`CPRU_OP_SECPLUS, 1'b0, 1, 0, 64'h0);
        chk_flag(sec, 1'b1);
        chk_flag(secp, 1'b0);
        chk_byte(8'(strobes), 8'h02);
        $display("unlock test done");
        read_test(`CPRU_OP_UREAD, 1'b0, 3'h3, 1, 16);
        read_test(`CPRU_OP_UREAD, 1'b0, 3'h7, 2, 52);
        read_test(`CPRU_OP_CREAD, 1'b0, 3'h0, 3, 64);
        read_test(`CPRU_OP_UREAD, 1'b1, 3'h5, 2, 68);
        large_device <= 1'b0;
        read_test(`CPRU_OP_CREAD, 1'b1, 3'h2, 1, 16);
        chk_flag(unlocked, 1'b1);
        @(posedge core_clk);
        resetn <= 1'b0;
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        @(negedge core_clk);
        chk_flag(unlocked, 1'b0);
        // key checking off: key is ignored, programming is permitted
        key_en <= 1'b0;
        run_cmd(`CPRU_OP_KEY, 1'b0, 1, 0, stored_key);
        chk_flag(unlocked, 1'b0);
        run_cmd(`CPRU_OP_BURST, 1'b0, 1, 0, 64'h0);
        chk_byte(8'(strobes), 8'h03);
        $display("reset test done");
        report_and_stop();
    end
endmodule : config_page_read_unlock_test
